/* File: hw/vwm_top.sv */
// vector word multiply-accumulate datapath top
// Behaviour
// - accumulator-initialise copies source into accumulator and destination, flags kept
// - signed fractional high multiply returns product bits 62 down to 31 per lane
// - high multiplies write accumulator only when accumulate-select bit set
// - signed integer high multiply returns upper 32 product bits per lane
// - saturating fractional: both most-negative gives largest positive and overflow
// - saturating fractional loads lane flags, ORs sticky flags, optional accumulate
// - unsigned high multiply returns upper 32 product bits per lane
// - modulo low accumulate adds low product to accumulator, flags unchanged
// - modulo low accumulate-negative subtracts low product, wrapping
// - saturating low accumulate clamps overflowed sum to extreme value
// - overflow where sum bits 31 and 32 differ, sets lane and sticky flags
// - saturating low accumulate-negative saturates and updates all overflow flags
`timescale 1ns/1ps
`default_nettype none
module vwm_top (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic CLK_EN,
  input wire logic ISSUE,
  input wire logic [31:0] INSTR,
  input wire logic [63:0] FIRST_SOURCE_REGISTER,
  input wire logic [63:0] SECOND_SOURCE_REGISTER,
  output logic [63:0] RESULT,
  output logic [4:0] RESULT_DEST,
  output logic RESULT_VALID,
  output logic ILLEGAL,
  output logic [63:0] ACCUMULATOR,
  output vwm_pkg::vwm_flags_t VECTOR_STATUS_CONTROL_REG
);

  ////////////////////////////////////////////////////////////////////////
  // decode
  vwm_pkg::vwm_op_t op;
  vwm_pkg::vwm_fields_t fld;
  logic [5:0] prim;
  logic [10:0] xop;

  // fixed field split keeps decode a pure slice
  always_comb
  begin
    prim = INSTR[vwm_pkg::PRIM_LSB +: vwm_pkg::PRIM_W];
    xop = INSTR[vwm_pkg::XOP_LSB +: vwm_pkg::XOP_W];
    fld.dest = INSTR[vwm_pkg::DEST_LSB +: vwm_pkg::REG_W];
    fld.srca = INSTR[vwm_pkg::SRCA_LSB +: vwm_pkg::REG_W];
    fld.srcb = INSTR[vwm_pkg::SRCB_LSB +: vwm_pkg::REG_W];
    fld.acc_sel = xop[vwm_pkg::ACC_SEL_BIT];
    op = vwm_pkg::VWM_NONE;
    if (prim == vwm_pkg::PRIM_VEC)
    begin
      case (xop & vwm_pkg::XOP_ACC_MASK)
        vwm_pkg::XOP_HI_SFRAC: op = vwm_pkg::VWM_HI_SFRAC;
        vwm_pkg::XOP_HI_SINT: op = vwm_pkg::VWM_HI_SINT;
        vwm_pkg::XOP_HI_SATF: op = vwm_pkg::VWM_HI_SATF;
        vwm_pkg::XOP_HI_UINT: op = vwm_pkg::VWM_HI_UINT;
        default: op = vwm_pkg::VWM_NONE;
      endcase
      // the remaining codes have no accumulate-select bit
      case (xop)
        vwm_pkg::XOP_ACC_INIT: op = vwm_pkg::VWM_ACC_INIT;
        vwm_pkg::XOP_LO_ADD: op = vwm_pkg::VWM_LO_ADD;
        vwm_pkg::XOP_LO_SUB: op = vwm_pkg::VWM_LO_SUB;
        vwm_pkg::XOP_LO_SATADD: op = vwm_pkg::VWM_LO_SATADD;
        vwm_pkg::XOP_LO_SATSUB: op = vwm_pkg::VWM_LO_SATSUB;
        default: op = op;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lane control
  logic sgn;
  logic frac;
  logic [2:0] mode;
  logic hi_form;
  logic sat_form;

  always_comb
  begin
    sgn = (op != vwm_pkg::VWM_HI_UINT);
    frac = (op == vwm_pkg::VWM_HI_SFRAC) || (op == vwm_pkg::VWM_HI_SATF);
    hi_form = (op == vwm_pkg::VWM_HI_SFRAC) || (op == vwm_pkg::VWM_HI_SINT) ||
              (op == vwm_pkg::VWM_HI_SATF) || (op == vwm_pkg::VWM_HI_UINT);
    sat_form = (op == vwm_pkg::VWM_HI_SATF) ||
               (op == vwm_pkg::VWM_LO_SATADD) ||
               (op == vwm_pkg::VWM_LO_SATSUB);
    case (op)
      vwm_pkg::VWM_HI_SATF: mode = 3'd1;
      vwm_pkg::VWM_LO_ADD: mode = 3'd2;
      vwm_pkg::VWM_LO_SUB: mode = 3'd3;
      vwm_pkg::VWM_LO_SATADD: mode = 3'd4;
      vwm_pkg::VWM_LO_SATSUB: mode = 3'd5;
      default: mode = 3'd0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // two lanes: index 0 is the upper (msb) lane
  logic [31:0] lane_res [2];
  logic lane_ovf [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_lane
      vwm_lane u_lane (
        .a(FIRST_SOURCE_REGISTER[63 - 32*g -: 32]),
        .b(SECOND_SOURCE_REGISTER[63 - 32*g -: 32]),
        .acc(ACCUMULATOR[63 - 32*g -: 32]),
        .sgn(sgn),
        .frac(frac),
        .mode(mode),
        .res(lane_res[g]),
        .ovf(lane_ovf[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // result, accumulator and status next values
  logic [63:0] next_result;
  logic [4:0] next_dest;
  logic next_valid;
  logic next_illegal;
  logic [63:0] next_acc;
  vwm_pkg::vwm_flags_t next_flags;
  logic go;

  always_comb
  begin
    go = CLK_EN && ISSUE;
    next_result = RESULT;
    next_dest = RESULT_DEST;
    next_valid = 1'b0;
    next_illegal = 1'b0;
    next_acc = ACCUMULATOR;
    next_flags = VECTOR_STATUS_CONTROL_REG;
    if (go && op == vwm_pkg::VWM_NONE)
      next_illegal = 1'b1;
    else if (go)
    begin
      next_valid = 1'b1;
      next_dest = fld.dest;
      if (op == vwm_pkg::VWM_ACC_INIT)
      begin
        next_result = FIRST_SOURCE_REGISTER;
        next_acc = FIRST_SOURCE_REGISTER;
      end
      else
      begin
        next_result = {lane_res[0], lane_res[1]};
        // high forms accumulate only on request, low forms always
        if (!hi_form || fld.acc_sel)
          next_acc = {lane_res[0], lane_res[1]};
      end
      if (sat_form)
      begin
        next_flags.upper_ovf = lane_ovf[0];
        next_flags.lower_lane_overflow_flag = lane_ovf[1];
        next_flags.upper_lane_sticky_overflow =
          VECTOR_STATUS_CONTROL_REG.upper_lane_sticky_overflow |
          lane_ovf[0];
        next_flags.lower_lane_sticky_overflow =
          VECTOR_STATUS_CONTROL_REG.lower_lane_sticky_overflow |
          lane_ovf[1];
      end
    end
  end

  // registered outputs; clock enable freezes everything
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      RESULT <= 64'h0000_0000_0000_0000;
      RESULT_DEST <= 5'h00;
      RESULT_VALID <= 1'b0;
      ILLEGAL <= 1'b0;
      ACCUMULATOR <= vwm_pkg::ACC_RESET;
      VECTOR_STATUS_CONTROL_REG <= 4'h0;
    end
    else if (CLK_EN)
    begin
      RESULT <= next_result;
      RESULT_DEST <= next_dest;
      RESULT_VALID <= next_valid;
      ILLEGAL <= next_illegal;
      ACCUMULATOR <= next_acc;
      VECTOR_STATUS_CONTROL_REG <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  acc_init_copy_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (go && op == vwm_pkg::VWM_ACC_INIT) |=>
      (ACCUMULATOR == $past(FIRST_SOURCE_REGISTER)) &&
      (RESULT == $past(FIRST_SOURCE_REGISTER)) &&
      $stable(VECTOR_STATUS_CONTROL_REG))
    else $error("accumulator init copy wrong");

  hi_acc_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (go && hi_form && !fld.acc_sel) |=> $stable(ACCUMULATOR))
    else $error("accumulator changed without select");

  hi_acc_write_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (go && hi_form && fld.acc_sel) |=> ACCUMULATOR == RESULT)
    else $error("accumulator not written with select");

  sint_high_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (go && op == vwm_pkg::VWM_HI_SINT) |=> RESULT[63:32] == 32'($past(
      64'($signed(FIRST_SOURCE_REGISTER[63:32]) *
      $signed(SECOND_SOURCE_REGISTER[63:32]))) >> 32))
    else $error("signed high product wrong");

  sat_frac_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (go && op == vwm_pkg::VWM_HI_SATF &&
     FIRST_SOURCE_REGISTER[31:0] == vwm_pkg::SAT_NEG &&
     SECOND_SOURCE_REGISTER[31:0] == vwm_pkg::SAT_NEG) |=>
      RESULT[31:0] == vwm_pkg::SAT_POS &&
      VECTOR_STATUS_CONTROL_REG.lower_lane_overflow_flag &&
      VECTOR_STATUS_CONTROL_REG.lower_lane_sticky_overflow)
    else $error("fractional saturation missed");

  sticky_keep_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    $past(VECTOR_STATUS_CONTROL_REG.upper_lane_sticky_overflow) |->
      VECTOR_STATUS_CONTROL_REG.upper_lane_sticky_overflow)
    else $error("sticky flag dropped");

  lo_add_flags_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (go && (op == vwm_pkg::VWM_LO_ADD || op == vwm_pkg::VWM_LO_SUB)) |=>
      $stable(VECTOR_STATUS_CONTROL_REG) && ACCUMULATOR == RESULT)
    else $error("modulo accumulate touched flags");

  lo_sub_wrap_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (go && op == vwm_pkg::VWM_LO_SUB) |=> RESULT[31:0] ==
      $past(ACCUMULATOR[31:0] - 32'(FIRST_SOURCE_REGISTER[31:0] *
      SECOND_SOURCE_REGISTER[31:0])))
    else $error("modulo subtract wrong");

  sat_clamp_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (go && (op == vwm_pkg::VWM_LO_SATADD ||
     op == vwm_pkg::VWM_LO_SATSUB) && lane_ovf[0]) |=>
      (RESULT[63:32] == vwm_pkg::SAT_NEG ||
       RESULT[63:32] == vwm_pkg::SAT_POS) &&
      VECTOR_STATUS_CONTROL_REG.upper_ovf)
    else $error("saturating accumulate clamp wrong");

  // fractional high keeps product bits 62 down to 31
  sfrac_high_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (go && op == vwm_pkg::VWM_HI_SFRAC) |=> RESULT[63:32] == 32'($past(
      64'($signed(FIRST_SOURCE_REGISTER[63:32]) *
      $signed(SECOND_SOURCE_REGISTER[63:32]))) >> 31))
    else $error("fractional high product wrong");

  uint_high_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (go && op == vwm_pkg::VWM_HI_UINT) |=> RESULT[31:0] == 32'($past(
      {32'h0000_0000, FIRST_SOURCE_REGISTER[31:0]} *
      {32'h0000_0000, SECOND_SOURCE_REGISTER[31:0]}) >> 32))
    else $error("unsigned high product wrong");

  // upper lane of the saturating fractional form
  sat_frac_hi_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (go && op == vwm_pkg::VWM_HI_SATF &&
     FIRST_SOURCE_REGISTER[63:32] == vwm_pkg::SAT_NEG &&
     SECOND_SOURCE_REGISTER[63:32] == vwm_pkg::SAT_NEG) |=>
      RESULT[63:32] == vwm_pkg::SAT_POS &&
      VECTOR_STATUS_CONTROL_REG.upper_ovf &&
      VECTOR_STATUS_CONTROL_REG.upper_lane_sticky_overflow)
    else $error("upper fractional saturation missed");

  lo_add_sum_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (go && op == vwm_pkg::VWM_LO_ADD) |=> RESULT[63:32] ==
      $past(ACCUMULATOR[63:32] + 32'(FIRST_SOURCE_REGISTER[63:32] *
      SECOND_SOURCE_REGISTER[63:32])))
    else $error("modulo add wrong");

  // lower lane clamp and both of its flags
  sat_lo_flag_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (go && (op == vwm_pkg::VWM_LO_SATADD ||
     op == vwm_pkg::VWM_LO_SATSUB) && lane_ovf[1]) |=>
      (RESULT[31:0] == vwm_pkg::SAT_NEG ||
       RESULT[31:0] == vwm_pkg::SAT_POS) &&
      VECTOR_STATUS_CONTROL_REG.lower_lane_overflow_flag &&
      VECTOR_STATUS_CONTROL_REG.lower_lane_sticky_overflow)
    else $error("lower saturating flags wrong");

  valid_pulse_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (go && op != vwm_pkg::VWM_NONE) |=> RESULT_VALID && !ILLEGAL)
    else $error("accepted op gave no valid");

  // a refused word must leave accumulator and flags alone
  illegal_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (go && op == vwm_pkg::VWM_NONE) |=> ILLEGAL && !RESULT_VALID &&
      $stable(ACCUMULATOR) && $stable(VECTOR_STATUS_CONTROL_REG))
    else $error("illegal op changed state");

  // clock enable low holds accumulator, result and flags
  freeze_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    !CLK_EN |=> $stable(ACCUMULATOR) && $stable(RESULT) &&
      $stable(VECTOR_STATUS_CONTROL_REG))
    else $error("state moved while frozen");

endmodule : vwm_top
`default_nettype wire

/* File: hw/vwm_pkg.sv */
// package for the vector word multiply-accumulate datapath
package vwm_pkg;

  localparam int unsigned LANE_W = 32;
  localparam int unsigned WORD_W = 64;
  localparam int unsigned PROD_W = 64;

  // instruction word field positions (lsb numbering, bit 31 = msb)
  localparam int unsigned PRIM_LSB = 26;
  localparam int unsigned PRIM_W = 6;
  localparam int unsigned DEST_LSB = 21;
  localparam int unsigned SRCA_LSB = 16;
  localparam int unsigned SRCB_LSB = 11;
  localparam int unsigned REG_W = 5;
  localparam int unsigned XOP_LSB = 0;
  localparam int unsigned XOP_W = 11;
  localparam int unsigned ACC_SEL_BIT = 5;

  // primary opcode shared by all vector operations
  localparam logic [5:0] PRIM_VEC = 6'h04;

  // extended opcodes, accumulate-select bit cleared where it applies
  localparam logic [10:0] XOP_ACC_INIT = 11'h0c4;
  localparam logic [10:0] XOP_HI_SFRAC = 11'h44f;
  localparam logic [10:0] XOP_HI_SINT = 11'h44d;
  localparam logic [10:0] XOP_HI_SATF = 11'h447;
  localparam logic [10:0] XOP_HI_UINT = 11'h44c;
  localparam logic [10:0] XOP_LO_ADD = 11'h549;
  localparam logic [10:0] XOP_LO_SUB = 11'h5c9;
  localparam logic [10:0] XOP_LO_SATADD = 11'h541;
  localparam logic [10:0] XOP_LO_SATSUB = 11'h5c1;
  localparam logic [10:0] XOP_ACC_MASK = 11'h7df;

  localparam logic [31:0] SAT_NEG = 32'h8000_0000;
  localparam logic [31:0] SAT_POS = 32'h7fff_ffff;
  localparam logic [63:0] ACC_RESET = 64'h0000_0000_0000_0000;

  typedef enum {
    VWM_NONE, VWM_ACC_INIT, VWM_HI_SFRAC, VWM_HI_SINT, VWM_HI_SATF,
    VWM_HI_UINT, VWM_LO_ADD, VWM_LO_SUB, VWM_LO_SATADD, VWM_LO_SATSUB
  } vwm_op_t;

  // status/control flag group
  typedef struct packed {
    logic upper_ovf;
    logic lower_lane_overflow_flag;
    logic upper_lane_sticky_overflow;
    logic lower_lane_sticky_overflow;
  } vwm_flags_t;

  // decoded instruction
  typedef struct packed {
    logic [4:0] dest;
    logic [4:0] srca;
    logic [4:0] srcb;
    logic acc_sel;
  } vwm_fields_t;

endpackage : vwm_pkg

/* File: hw/vwm_lane.sv */
// one 32-bit lane: multiply, high/low select, accumulate and saturate
`timescale 1ns/1ps
`default_nettype none
module vwm_lane (
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  input wire logic [31:0] acc,
  input wire logic sgn,
  input wire logic frac,
  input wire logic [2:0] mode,
  output logic [31:0] res,
  output logic ovf
);
  // mode: 0 high, 1 sat-frac high, 2 add, 3 sub, 4 sat add, 5 sat sub
  logic [63:0] prod;
  logic [63:0] fprod;
  logic [32:0] ext;
  logic both_neg;

  always_comb
  begin
    prod = sgn ? 64'($signed(a) * $signed(b)) : 64'(a * b);
    // fractional keeps the binary point: one left shift
    fprod = frac ? {prod[62:0], 1'b0} : prod;
    both_neg = (a == vwm_pkg::SAT_NEG) && (b == vwm_pkg::SAT_NEG);
    ext = 33'h0_0000_0000;
    res = fprod[63:32];
    ovf = 1'b0;
    case (mode)
      3'd1:
      begin
        if (both_neg)
        begin
          res = vwm_pkg::SAT_POS;
          ovf = 1'b1;
        end
      end
      3'd2: res = acc + prod[31:0];
      3'd3: res = acc - prod[31:0];
      3'd4, 3'd5:
      begin
        // overflow shows where bits 31 and 32 of the sum disagree
        ext = (mode == 3'd4) ?
          {acc[31], acc} + {prod[31], prod[31:0]} :
          {acc[31], acc} - {prod[31], prod[31:0]};
        ovf = ext[32] ^ ext[31];
        res = ovf ? (ext[32] ? vwm_pkg::SAT_NEG : vwm_pkg::SAT_POS)
                  : ext[31:0];
      end
      default: res = fprod[63:32];
    endcase
  end
endmodule : vwm_lane
`default_nettype wire

/* File: sim/vwm_core_model.sv */
// core-side model: register file feeding sources, taking writebacks
`timescale 1ns/1ps
`default_nettype none
module vwm_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] instr,
  input wire logic ld_en,
  input wire logic [63:0] ld_a,
  input wire logic [63:0] ld_b,
  input wire logic [63:0] result,
  input wire logic [4:0] result_dest,
  input wire logic result_valid,
  output logic [63:0] src_a,
  output logic [63:0] src_b
);
  logic [63:0] regs [32];

  ////////////////////////////////////////////////////////////////////////////
  // operand reads, indexed by the register fields of the word
  assign src_a = regs[instr[20:16]];
  assign src_b = regs[instr[15:11]];

  ////////////////////////////////////////////////////////////////////////////
  // preload port for the bench, then the pipe's writeback
  // writeback is applied last so it wins on a clash, like a real pipe
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 32; i++)
        regs[i] <= 64'h0;
    end
    else
    begin
      if (ld_en)
      begin
        regs[instr[20:16]] <= ld_a;
        regs[instr[15:11]] <= ld_b;
      end
      if (result_valid)
        regs[result_dest] <= result;
    end
  end
endmodule : vwm_core_model
`default_nettype wire

/* File: sim/vwm_top_tb_top.sv */
// self-checking bench for the vector word multiply-accumulate datapath
`timescale 1ns/1ps
`default_nettype none
module vwm_top_tb_top;
  typedef struct packed {
    logic [10:0] xop;
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] res;
    logic wr;
    logic [3:0] flg;
  } vwm_row_t;

  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic issue = 1'b0;
  logic ld_en = 1'b0;
  logic [10:0] xop = 11'h000;
  logic [63:0] ld_a = 64'h0;
  logic [63:0] ld_b = 64'h0;
  logic [63:0] exp_acc = 64'h0;
  logic [31:0] instr;
  logic [63:0] src_a, src_b, result, accumulator;
  logic [4:0] result_dest;
  logic result_valid, illegal;
  vwm_pkg::vwm_flags_t flags;
  int mismatches = 0;
  int num_checks = 0;

  // chained rows: accumulator and sticky flags carry from row to row
  // operands keep low products within 32 bits on purpose
  vwm_row_t rows [10] = '{
    '{vwm_pkg::XOP_ACC_INIT, 64'h0000_0005_ffff_fffe,
      64'h0, 64'h0000_0005_ffff_fffe, 1'b1, 4'h0},
    '{vwm_pkg::XOP_HI_SINT, 64'h0001_0000_ffff_ffff,
      64'h0001_0000_0000_0002, 64'h0000_0001_ffff_ffff, 1'b0, 4'h0},
    '{vwm_pkg::XOP_HI_UINT | 11'h020, 64'hffff_ffff_8000_0000,
      64'h0000_0002_0000_0004, 64'h0000_0001_0000_0002, 1'b1, 4'h0},
    '{vwm_pkg::XOP_HI_SFRAC, 64'h4000_0000_c000_0000,
      64'h4000_0000_4000_0000, 64'h2000_0000_e000_0000, 1'b0, 4'h0},
    '{vwm_pkg::XOP_HI_SATF | 11'h020, 64'h8000_0000_8000_0000,
      64'h8000_0000_4000_0000, 64'h7fff_ffff_c000_0000, 1'b1, 4'ha},
    '{vwm_pkg::XOP_LO_ADD, 64'h0000_0003_0000_0002,
      64'h0000_0004_ffff_ffff, 64'h8000_000b_bfff_fffe, 1'b1, 4'ha},
    '{vwm_pkg::XOP_LO_SUB, 64'h0000_0001_0000_0010,
      64'h0000_000c_0000_0001, 64'h7fff_ffff_bfff_ffee, 1'b1, 4'ha},
    '{vwm_pkg::XOP_LO_SATADD, 64'h0000_0001_ffff_ffff,
      64'h0000_0001_4000_0001, 64'h7fff_ffff_8000_0000, 1'b1, 4'hf},
    '{vwm_pkg::XOP_LO_SATSUB, 64'h0000_0001_0000_0001,
      64'h0000_0001_0000_0005, 64'h7fff_fffe_8000_0000, 1'b1, 4'h7},
    '{vwm_pkg::XOP_LO_SATADD, 64'h0000_0001_0000_0001,
      64'h0000_0001_0000_0001, 64'h7fff_ffff_8000_0001, 1'b1, 4'h3}
  };

  // fixed dest 3, sources 1 and 2 so the writeback never hits a source
  assign instr = {vwm_pkg::PRIM_VEC, 5'h03, 5'h01, 5'h02, xop};

  always #10 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  vwm_top u_vwm_top (
    .CLK_SYS(clk_sys),
    .RESET(reset),
    .CLK_EN(clk_en),
    .ISSUE(issue),
    .INSTR(instr),
    .FIRST_SOURCE_REGISTER(src_a),
    .SECOND_SOURCE_REGISTER(src_b),
    .RESULT(result),
    .RESULT_DEST(result_dest),
    .RESULT_VALID(result_valid),
    .ILLEGAL(illegal),
    .ACCUMULATOR(accumulator),
    .VECTOR_STATUS_CONTROL_REG(flags)
  );

  vwm_core_model u_vwm_core_model (
    .clk(clk_sys),
    .rst(reset),
    .instr(instr),
    .ld_en(ld_en),
    .ld_a(ld_a),
    .ld_b(ld_b),
    .result(result),
    .result_dest(result_dest),
    .result_valid(result_valid),
    .src_a(src_a),
    .src_b(src_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shared compare; four-state equality so unknowns never match
  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // preload sources, issue one op; returns in the answer cycle
  task automatic run_op(input logic [10:0] op, input logic [63:0] a,
                        input logic [63:0] b);
    @(negedge clk_sys);
    xop = op;
    ld_a = a;
    ld_b = b;
    ld_en = 1'b1;
    @(negedge clk_sys);
    ld_en = 1'b0;
    issue = 1'b1;
    @(negedge clk_sys);
    issue = 1'b0;
  endtask : run_op

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, well past the roughly 56 cycles the sequence needs
  initial
  begin
    repeat (1000) @(posedge clk_sys);
    mismatches++;
    test_done();
  end

  // main sequence
  initial
  begin
    repeat (12) @(negedge clk_sys);
    chk(accumulator, 64'h0, "reset acc");
    chk(64'(flags), 64'h0, "reset flags");
    reset = 1'b0;
    foreach (rows[i])
    begin
      run_op(rows[i].xop, rows[i].a, rows[i].b);
      if (rows[i].wr)
        exp_acc = rows[i].res;
      chk(result, rows[i].res, "result");
      chk(accumulator, exp_acc, "acc");
      chk(64'(flags), 64'(rows[i].flg), "flags");
      chk(64'(result_valid), 64'h1, "valid");
      chk(64'(result_dest), 64'h3, "dest");
    end
    // back to back: second op must see the first op's accumulator
    // issue stays high over two edges so the ops really abut
    @(negedge clk_sys);
    xop = vwm_pkg::XOP_LO_ADD;
    ld_a = 64'h0000_0001_0000_0002;
    ld_b = 64'h0000_0001_0000_0003;
    ld_en = 1'b1;
    @(negedge clk_sys);
    ld_en = 1'b0;
    issue = 1'b1;
    @(negedge clk_sys);
    chk(result, 64'h8000_0000_8000_0007, "b2b first");
    @(negedge clk_sys);
    issue = 1'b0;
    chk(accumulator, 64'h8000_0001_8000_000d, "b2b second");
    chk(64'(flags), 64'h3, "b2b flags");
    @(negedge clk_sys);
    chk(64'(result_valid), 64'h1 ^ 64'h1, "valid pulse");
    // undecoded extended opcode: refused, state untouched
    run_op(11'h000, 64'h1, 64'h1);
    chk(64'(illegal), 64'h1, "illegal");
    chk(64'(result_valid), 64'h0, "illegal valid");
    chk(accumulator, 64'h8000_0001_8000_000d, "illegal acc");
    // clock enable low: an issued op is not taken
    @(negedge clk_sys);
    xop = vwm_pkg::XOP_LO_ADD;
    clk_en = 1'b0;
    issue = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(accumulator, 64'h8000_0001_8000_000d, "frozen acc");
    chk(64'(result_valid), 64'h0, "frozen valid");
    issue = 1'b0;
    clk_en = 1'b1;
    // reset in mid-run clears accumulator and every flag
    @(negedge clk_sys);
    reset = 1'b1;
    @(negedge clk_sys);
    chk(accumulator, 64'h0, "rerun acc");
    chk(64'(flags), 64'h0, "rerun flags");
    reset = 1'b0;
    // first edge after release: nothing issued, outputs stay cleared
    @(negedge clk_sys);
    chk(64'(result_valid), 64'h0, "release valid");
    chk(64'(illegal), 64'h0, "release illegal");
    chk(result, 64'h0, "release result");
    test_done();
  end
endmodule : vwm_top_tb_top
`default_nettype wire
